// ==== hdl/rfpc_defines.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the RF front-end pin control block.
 * Assumes a 125 MHz system clock and a classic Wishbone slave with 32-bit data.
 */
`ifndef RFPC_DEFINES_SVH
`define RFPC_DEFINES_SVH

// Register byte addresses
`define RFPC_ADDR_MODE      8'h00
`define RFPC_ADDR_RAMP      8'h04
`define RFPC_ADDR_DAC       8'h08
`define RFPC_ADDR_CTRL      8'h0C
`define RFPC_ADDR_STATUS    8'h10

// Persistent key numbers, pin mode and ramp delay keys readable in the upper half of the mode and ramp registers
`define RFPC_KEY_INPUT_STYLE  16'h0020
`define RFPC_KEY_PIN_MODE     16'h0209
`define RFPC_KEY_RAMP_DELAY   16'h001D

// Field positions
`define RFPC_RAMP_DLY_HI    15
`define RFPC_RAMP_DLY_LO    8
`define RFPC_MODE_DIFF_BIT  8
`define RFPC_CTRL_RX_BIT    0
`define RFPC_CTRL_TX_BIT    1

// Reset values
`define RFPC_MODE_RST       3'h0
`define RFPC_RAMP_RST       16'h0000
`define RFPC_DAC_RST        8'h00

// Timing
`define RFPC_CLK_MHZ        125
`define RFPC_US_CYCLES      8'd125
`define RFPC_RAMP_STEPS     8'hFF

`endif

// ==== hdl/rfpc_pkg.sv ====
/*
 * Types shared by the RF front-end pin control block.
 * Assumes nothing beyond the defines header.
 */
package rfpc_pkg;

    typedef enum logic [2:0] {
        RFPC_IDLE,
        RFPC_RAMP_UP,
        RFPC_CARRIER,
        RFPC_MODULATE,
        RFPC_RAMP_DOWN
    } rfpc_tx_state_t;

    typedef struct packed {
        logic       pin_active_high;
        logic       pins_used;
        logic       dac_used;
        logic       ramp_internal;
    } rfpc_mode_decode_t;

endpackage

// ==== hdl/rfpc_frontend.sv ====
/*
 * RF front-end pin control: indicator pins, PA enable, power ramp, carrier hold and DAC word.
 * Assumes a classic Wishbone master, synchronous inputs and one 125 MHz clock.
 */
// The register addresses and the Wishbone register port were chosen for this implementation.
// Summary of operation
// - A stored configuration bit selects a single-ended or differential receive input.
// - A stored front-end mode value decides how the indicator pins and DAC drive external parts.
// - Mode 0 leaves both pins and the DAC unused and ramps power internally.
// - Modes 1, 2 and 4 drive the receive pin high in reception and the transmit pin high in transmission.
// - Mode 3 drives the receive pin low in reception and the transmit pin low in transmission.
// - Mode 1 leaves the DAC unused, while modes 2, 3 and 4 let the DAC set external amplifier gain.
// - Modes 2 and 3 leave ramping to the external amplifier, modes 0, 1 and 4 ramp internally.
// - The external amplifier is enabled only while a transmission is in progress.
// - With internal ramping, power is raised before a transmission and lowered after it.
// - Bits 15 to 8 of the ramp key give the post-ramp delay in microseconds.
// - An unmodulated carrier is sent during that delay and modulation starts only after it.
// - External gain is set by an 8-bit DAC word that scales as word over 255 of full scale.
`include "rfpc_defines.svh"

module rfpc_frontend (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Radio activity
    input  wire logic        rx_active_i,
    input  wire logic        tx_request_i,
    // Front-end pins
    output logic             rx_indicate_pin_o,
    output logic             tx_indicate_pin_o,
    output logic             pa_enable_o,
    output logic [7:0]       pa_power_pin_o,
    output logic [7:0]       int_pa_level_o,
    output logic             carrier_only_o,
    output logic             modulate_o,
    output logic             rf_receive_input_diff_o
);

    logic [2:0]                  rf_pin_mode_select;
    logic                        rx_input_diff;
    logic [15:0]                 tx_ramp_carrier_delay_key;
    logic [7:0]                  dac_level_word;
    rfpc_pkg::rfpc_mode_decode_t dec;
    rfpc_pkg::rfpc_tx_state_t    state;
    logic [7:0]                  ramp_level;
    logic [7:0]                  us_div;
    logic [7:0]                  us_left;
    logic                        wb_req;
    logic                        tx_busy;

    assign wb_req  = cyc_i && stb_i && !ack_o;
    assign tx_busy = state != rfpc_pkg::RFPC_IDLE;

    // Mode decode
    always_comb begin
        dec.pins_used       = rf_pin_mode_select != 3'h0;
        dec.pin_active_high = rf_pin_mode_select != 3'h3;
        dec.dac_used        = rf_pin_mode_select >= 3'h2 && rf_pin_mode_select <= 3'h4;
        dec.ramp_internal   = rf_pin_mode_select != 3'h2 && rf_pin_mode_select != 3'h3;
    end

    // Bus acknowledge, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_req;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rf_pin_mode_select        <= `RFPC_MODE_RST;
            rx_input_diff             <= 1'b0;
            tx_ramp_carrier_delay_key <= `RFPC_RAMP_RST;
            dac_level_word            <= `RFPC_DAC_RST;
        end else if (wb_req && we_i) begin
            case (adr_i)
                `RFPC_ADDR_MODE: begin
                    if (sel_i[0]) begin
                        rf_pin_mode_select <= dat_i[2:0];
                    end
                    if (sel_i[1]) begin
                        rx_input_diff <= dat_i[`RFPC_MODE_DIFF_BIT];
                    end
                end
                `RFPC_ADDR_RAMP: begin
                    if (sel_i[0]) begin
                        tx_ramp_carrier_delay_key[7:0] <= dat_i[7:0];
                    end
                    if (sel_i[1]) begin
                        tx_ramp_carrier_delay_key[15:8] <= dat_i[15:8];
                    end
                end
                `RFPC_ADDR_DAC: begin
                    if (sel_i[0]) begin
                        dac_level_word <= dat_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (wb_req && !we_i) begin
            case (adr_i)
                `RFPC_ADDR_MODE:   dat_o <= {`RFPC_KEY_PIN_MODE, 7'h0, rx_input_diff, 5'h0, rf_pin_mode_select};
                `RFPC_ADDR_RAMP:   dat_o <= {`RFPC_KEY_RAMP_DELAY, tx_ramp_carrier_delay_key};
                `RFPC_ADDR_DAC:    dat_o <= {24'h0, dac_level_word};
                `RFPC_ADDR_STATUS: dat_o <= {16'h0, ramp_level, 2'h0, modulate_o, carrier_only_o,
                                             pa_enable_o, state};
                default:           dat_o <= 32'h0;
            endcase
        end
    end

    // Transmit sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= rfpc_pkg::RFPC_IDLE;
            ramp_level <= 8'h00;
            us_div     <= 8'h00;
            us_left    <= 8'h00;
        end else begin
            case (state)
                rfpc_pkg::RFPC_IDLE: begin
                    ramp_level <= 8'h00;
                    if (tx_request_i) begin
                        state <= rfpc_pkg::RFPC_RAMP_UP;
                    end
                end
                rfpc_pkg::RFPC_RAMP_UP: begin
                    if (!dec.ramp_internal || ramp_level == `RFPC_RAMP_STEPS) begin
                        state   <= rfpc_pkg::RFPC_CARRIER;
                        us_left <= tx_ramp_carrier_delay_key[`RFPC_RAMP_DLY_HI:`RFPC_RAMP_DLY_LO];
                        us_div  <= 8'h00;
                    end else begin
                        ramp_level <= ramp_level + 8'h01;
                    end
                end
                rfpc_pkg::RFPC_CARRIER: begin
                    if (us_left == 8'h00) begin
                        state <= rfpc_pkg::RFPC_MODULATE;
                    end else if (us_div == `RFPC_US_CYCLES - 8'h01) begin
                        us_div  <= 8'h00;
                        us_left <= us_left - 8'h01;
                    end else begin
                        us_div <= us_div + 8'h01;
                    end
                end
                rfpc_pkg::RFPC_MODULATE: begin
                    if (!tx_request_i) begin
                        state <= rfpc_pkg::RFPC_RAMP_DOWN;
                    end
                end
                rfpc_pkg::RFPC_RAMP_DOWN: begin
                    if (!dec.ramp_internal || ramp_level == 8'h00) begin
                        state      <= rfpc_pkg::RFPC_IDLE;
                        ramp_level <= 8'h00;
                    end else begin
                        ramp_level <= ramp_level - 8'h01;
                    end
                end
                default: begin
                    state <= rfpc_pkg::RFPC_IDLE;
                end
            endcase
        end
    end

    // Receive input style
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rf_receive_input_diff_o <= 1'b0;
        end else begin
            rf_receive_input_diff_o <= rx_input_diff;
        end
    end

    a_diff_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && we_i && adr_i == `RFPC_ADDR_MODE && sel_i[1]
        |=> ##1 rf_receive_input_diff_o == $past(dat_i[`RFPC_MODE_DIFF_BIT], 2)) else $error("diff input not stored");

    // Receive indicator, quiet while transmitting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_indicate_pin_o <= 1'b0;
        end else if (dec.pins_used) begin
            rx_indicate_pin_o <= (rx_active_i && !tx_busy) ~^ dec.pin_active_high;
        end else begin
            rx_indicate_pin_o <= 1'b0;
        end
    end

    a_rx_high_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        (rf_pin_mode_select inside {3'h1, 3'h2, 3'h4}) && rx_active_i && !tx_busy |=> rx_indicate_pin_o)
        else $error("active-high rx pin low");

    a_rx_low_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        rf_pin_mode_select == 3'h3 && rx_active_i && !tx_busy |=> !rx_indicate_pin_o) else $error("mode 3 rx pin high");

    // Transmit indicator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_indicate_pin_o <= 1'b0;
        end else if (dec.pins_used) begin
            tx_indicate_pin_o <= tx_busy ~^ dec.pin_active_high;
        end else begin
            tx_indicate_pin_o <= 1'b0;
        end
    end

    a_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (rf_pin_mode_select inside {3'h1, 3'h2, 3'h4}) && !tx_busy && !rx_active_i
        |=> !rx_indicate_pin_o && !tx_indicate_pin_o) else $error("active-high idle pins not low");

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_enable_o <= 1'b0;
        end else begin
            pa_enable_o <= dec.pins_used && tx_busy;
        end
    end

    a_pa_during_tx: assert property (@(posedge clk_i) disable iff (rst_i)
        rf_pin_mode_select != 3'h0 && tx_busy |=> pa_enable_o) else $error("PA off during transmission");

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_power_pin_o <= 8'h00;
        end else begin
            pa_power_pin_o <= (dec.dac_used && tx_busy) ? dac_level_word : 8'h00;
        end
    end

    a_dac_gain: assert property (@(posedge clk_i) disable iff (rst_i)
        (rf_pin_mode_select inside {3'h2, 3'h3, 3'h4}) && tx_busy |=> pa_power_pin_o == $past(dac_level_word))
        else $error("DAC word not driven");

    // Internal PA level steps 0 to full with internal ramping, and jumps to full when the amplifier ramps externally
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_pa_level_o <= 8'h00;
        end else begin
            int_pa_level_o <= dec.ramp_internal ? ramp_level : (tx_busy ? 8'hFF : 8'h00);
        end
    end

    a_ext_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !dec.ramp_internal |=> int_pa_level_o == ($past(tx_busy) ? 8'hFF : 8'h00)) else $error("external level wrong");

    a_int_level: assert property (@(posedge clk_i) disable iff (rst_i)
        dec.ramp_internal |=> int_pa_level_o == $past(ramp_level)) else $error("internal level wrong");

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carrier_only_o <= 1'b0;
        end else begin
            carrier_only_o <= state == rfpc_pkg::RFPC_CARRIER;
        end
    end

    a_carrier_out: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_CARRIER |=> carrier_only_o && !modulate_o) else $error("carrier flag wrong");

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulate_o <= 1'b0;
        end else begin
            modulate_o <= state == rfpc_pkg::RFPC_MODULATE;
        end
    end

    a_no_mod_carrier: assert property (@(posedge clk_i) disable iff (rst_i)
        !(carrier_only_o && modulate_o)) else $error("modulation during carrier hold");

    a_mode_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && we_i && adr_i == `RFPC_ADDR_MODE && sel_i[0]
        |=> rf_pin_mode_select == $past(dat_i[2:0])) else $error("mode not stored");

    a_ramp_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && we_i && adr_i == `RFPC_ADDR_RAMP && sel_i[1]
        |=> tx_ramp_carrier_delay_key[15:8] == $past(dat_i[15:8])) else $error("delay not stored");

    a_dac_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && we_i && adr_i == `RFPC_ADDR_DAC && sel_i[0]
        |=> dac_level_word == $past(dat_i[7:0])) else $error("DAC word not stored");

    a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> ack_o) else $error("request not acknowledged");

    a_ramp_falls: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_RAMP_DOWN && dec.ramp_internal && ramp_level != 8'h00
        |=> ramp_level == $past(ramp_level) - 8'h01) else $error("ramp not falling");

    a_idle_stays: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_IDLE && !tx_request_i |=> state == rfpc_pkg::RFPC_IDLE)
        else $error("transmission without request");

    a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held two cycles");
    a_pa_only_tx: assert property (@(posedge clk_i) disable iff (rst_i)
        pa_enable_o |-> $past(tx_busy)) else $error("PA enabled outside transmission");
    a_mode0_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rf_pin_mode_select) == 3'h0 |-> !rx_indicate_pin_o && !tx_indicate_pin_o && pa_power_pin_o == 8'h00)
        else $error("mode 0 pins not idle");
    a_high_tx_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        (rf_pin_mode_select inside {3'h1, 3'h2, 3'h4}) && tx_busy |=> tx_indicate_pin_o)
        else $error("active-high tx pin low");
    a_low_tx_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        rf_pin_mode_select == 3'h3 && tx_busy |=> !tx_indicate_pin_o) else $error("mode 3 tx pin high");
    a_idle_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        rf_pin_mode_select == 3'h3 && !tx_busy && !rx_active_i |=> rx_indicate_pin_o && tx_indicate_pin_o)
        else $error("mode 3 idle pins not high");
    a_dac_mode1: assert property (@(posedge clk_i) disable iff (rst_i)
        rf_pin_mode_select == 3'h1 |=> pa_power_pin_o == 8'h00) else $error("DAC used in mode 1");
    a_ext_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_RAMP_UP && !dec.ramp_internal |=> state == rfpc_pkg::RFPC_CARRIER)
        else $error("external ramp not skipped");
    a_ramp_rises: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_RAMP_UP && dec.ramp_internal && ramp_level != 8'hFF
        |=> ramp_level == $past(ramp_level) + 8'h01) else $error("ramp not rising");
    a_carrier_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_CARRIER && us_left == 8'h00 |=> state == rfpc_pkg::RFPC_MODULATE)
        else $error("carrier hold overran");
    a_carrier_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rfpc_pkg::RFPC_CARRIER && us_left != 8'h00 && us_div == 8'h00
        |-> ##124 us_div == 8'd124 ##1 us_left == $past(us_left, 125) - 8'h01) else $error("microsecond count wrong");

endmodule

// ==== tb/rfpc_fe_model.sv ====
/*
 * Behavioural model of the external RF switch, PA and LNA driven by the front-end pins.
 * Assumes the bench tells it whether the pin polarity is inverted for the current mode.
 */
module rfpc_fe_model (
    // Pins from the device, and the polarity flag from the bench
    input  wire logic       rx_pin_i,
    input  wire logic       tx_pin_i,
    input  wire logic       pa_enable_i,
    input  wire logic [7:0] pa_power_i,
    input  wire logic       inverted_i,
    // Model state
    output logic            sw_tx_o,
    output logic            lna_on_o,
    output logic [7:0]      pa_gain_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign sw_tx_o   = tx_pin_i ^ inverted_i;
    assign lna_on_o  = rx_pin_i ^ inverted_i;
    // A disabled PA passes no gain whatever the DAC level says
    assign pa_gain_o = pa_enable_i ? pa_power_i : 8'h00;
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the RF front-end pin control block.
 * Assumes the design answers Wishbone one cycle after a request.
 */
`include "rfpc_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        rx_active_i = 0, tx_request_i = 0, inv = 0;
    logic [7:0]  adr_i = 0;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0, rd;
    wire logic [31:0] dat_o;
    wire logic        ack_o, rx_pin, tx_pin, pa_en, carrier, modul, diff, sw_tx, lna_on;
    wire logic [7:0]  pa_pwr, int_lvl, pa_gain;
    int          err_count = 0, check_count = 0;
    int          m, n, ramp, carr, dly;
    logic        hi, used, dac_on, intl;
    logic [7:0]  word, top;
    always #4 clk_i = ~clk_i;
    rfpc_frontend dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_active_i(rx_active_i), .tx_request_i(tx_request_i), .rx_indicate_pin_o(rx_pin),
        .tx_indicate_pin_o(tx_pin), .pa_enable_o(pa_en), .pa_power_pin_o(pa_pwr),
        .int_pa_level_o(int_lvl), .carrier_only_o(carrier), .modulate_o(modul),
        .rf_receive_input_diff_o(diff));
    rfpc_fe_model fe_u (.rx_pin_i(rx_pin), .tx_pin_i(tx_pin), .pa_enable_i(pa_en),
        .pa_power_i(pa_pwr), .inverted_i(inv), .sw_tx_o(sw_tx), .lna_on_o(lna_on), .pa_gain_o(pa_gain));
    task automatic stop_test();
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (ack_o !== 1'b1) begin
            err_count++;
            stop_test();
        end
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    initial begin
        void'($urandom(32'h4fb87543));
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(0, `RFPC_ADDR_MODE, 0);
        chk(rd, 32'h0209_0000);
        wb(0, `RFPC_ADDR_RAMP, 0);
        chk(rd, 32'h001D_0000);
        wb(1, `RFPC_ADDR_CTRL, 32'h0000_00FF);
        wb(0, `RFPC_ADDR_CTRL, 0);
        chk(rd, 32'h0000_0000);
        wb(0, `RFPC_ADDR_STATUS, 0);
        chk(rd, 32'h0000_0000);
        wb(1, `RFPC_ADDR_MODE, 32'h0000_0100);
        chk({31'h0, diff}, 32'h1);
        for (m = 0; m < 5; m++) begin
            hi = (m != 3);
            used = (m != 0);
            dac_on = (m >= 2);
            intl = (m != 2 && m != 3);
            dly = m;
            word = 8'($urandom_range(1, 255));
            inv <= !hi;
            wb(1, `RFPC_ADDR_MODE, m);
            wb(1, `RFPC_ADDR_RAMP, {16'h0, 8'(dly), 8'($urandom)});
            wb(1, `RFPC_ADDR_DAC, {24'h0, word});
            wb(0, `RFPC_ADDR_MODE, 0);
            chk(rd, {16'h0209, 13'h0, 3'(m)});
            chk({31'h0, diff}, 32'h0);
            chk({tx_pin, rx_pin}, used ? {!hi, !hi} : 2'b00);
            rx_active_i <= 1;
            repeat (3) @(posedge clk_i);
            chk({tx_pin, rx_pin}, used ? {!hi, hi} : 2'b00);
            if (used)
                chk({31'h0, lna_on}, 32'h1);
            rx_active_i <= 0;
            tx_request_i <= 1;
            ramp = 0;
            carr = 0;
            top = 0;
            for (n = 0; n < 2000 && modul !== 1'b1; n++) begin
                @(negedge clk_i);
                if (int_lvl > top)
                    top = int_lvl;
                if (carrier === 1'b1)
                    carr++;
                else if (carr == 0)
                    ramp++;
                if (carrier === 1'b1 && modul === 1'b1)
                    chk(0, 1);
            end
            if (modul !== 1'b1) begin
                err_count++;
                stop_test();
            end
            chk(carr, dly * 125 + 1);
            chk(ramp >= 255, intl);
            chk(top, 8'hFF);
            chk({pa_en, tx_pin, rx_pin}, used ? {1'b1, hi, !hi} : 3'b000);
            chk(pa_pwr, dac_on ? word : 8'h00);
            chk(pa_gain, dac_on ? word : 8'h00);
            if (used)
                chk({31'h0, sw_tx}, 32'h1);
            @(posedge clk_i);
            tx_request_i <= 0;
            for (n = 0; n < 600 && (pa_en !== 1'b0 || modul !== 1'b0 || int_lvl !== 8'h00); n++)
                @(negedge clk_i);
            if (n >= 600) begin
                err_count++;
                stop_test();
            end
            repeat (3) @(posedge clk_i);
            chk({pa_en, modul, carrier}, 3'b000);
            chk(int_lvl, 8'h00);
            chk(pa_pwr, 8'h00);
            chk({tx_pin, rx_pin}, used ? {!hi, !hi} : 2'b00);
        end
        stop_test();
    end
endmodule
